// [tpg_consts.vh]
/*
 * constants for the timer / pulse generator: register offsets,
 * field positions, reset values and timing counts.
 * assumes it is included by bare name from the design files.
 */
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TPG_MODE_OFS 12'hF90
`define TPG_MODULO_LOW_REG_OFS 12'hF94
`define TPG_MODULO_HIGH_REG_OFS 12'hF98
`define TPG_STAT_OFS 12'hF9C
`define TPG_RELOAD_OFS 12'hFA0

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define TPG_MODE_SEL 0
`define TPG_RUN_EN 1
`define TPG_RELOAD_EN 3
`define TPG_STATIC_LVL 4
`define TPG_PULSE_SEL 5
`define TPG_PIN_EN 7
`define TPG_MODE_RMASK 8'hBB
`define TPG_MODE_RST 8'h00
`define TPG_MOD_RST 8'h00

// ----------------------------------------
// timing counter widths in bits, basic and secondary periods are 2^n main clock cycles
// ----------------------------------------
`define TPG_BASIC_BITS 10
`define TPG_SECOND_BITS 15
`define TPG_PWM_BITS 14

// ----------------------------------------
// bus answers
// ----------------------------------------
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2

`endif

// [pwm_core.v]
/*
 * 14-bit pwm engine: basic period of 2^10 clocks, secondary period
 * of 2^15 clocks, active-low output, one period end pulse per secondary period.
 * assumes the latch value is stable or changes only between cycles.
 */
`timescale 1ns/1ps
`include "tpg_consts.vh"

module pwm_core #(
    parameter BASIC_BITS = `TPG_BASIC_BITS,
    parameter SECOND_BITS = `TPG_SECOND_BITS,
    parameter PWM_BITS = `TPG_PWM_BITS
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [PWM_BITS-1:0] latch_value,
    output reg pwm_out_reg,
    output reg period_end_reg
);

    localparam SUB_BITS = SECOND_BITS - BASIC_BITS;
    localparam FRAC_BITS = PWM_BITS - BASIC_BITS;

    reg [SECOND_BITS-1:0] cnt_reg;
    wire [BASIC_BITS-1:0] phase;
    wire [SUB_BITS-1:0] sub_index;
    wire [BASIC_BITS-1:0] base_width;
    wire [SUB_BITS-1:0] extra_limit;
    wire extra;

    assign phase = cnt_reg[BASIC_BITS-1:0];
    assign sub_index = cnt_reg[SECOND_BITS-1:BASIC_BITS];
    assign base_width = latch_value[PWM_BITS-1:FRAC_BITS];
    // fraction spread
    // low nibble adds one clock in 2*frac of the 32 basic periods,
    // so mean low time stays exactly value/16 clocks per period
    assign extra_limit = {latch_value[FRAC_BITS-1:0], 1'b0};
    assign extra = (sub_index < extra_limit);

    // ----------------------------------------
    // period counter and output
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= {SECOND_BITS{1'b0}};
            pwm_out_reg <= 1'b1;
            period_end_reg <= 1'b0;
        end else if (!run) begin
            cnt_reg <= {SECOND_BITS{1'b0}};
            pwm_out_reg <= 1'b1;
            period_end_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            pwm_out_reg <= !((phase < base_width) ||
                ((phase == base_width) && extra));
            period_end_reg <= (cnt_reg == {SECOND_BITS{1'b1}});
        end
    end

endmodule

// [timer_pulse_generator.v]
/*
 * timer / pulse generator with an axi4-lite register slave.
 * timer mode: prescaled 8-bit interval timer with square wave.
 * pwm mode: 14-bit active-low pwm and a periodic event.
 * assumes a single clock and synchronous active-low reset.
 */
// How it works
// - reset clears the whole mode register
// - mode bit 0 pwm, 1 timer
// - run enable low halts timer and pwm counters
// - reload enable gates latch, writable alone
// - static level bit drives static latch
// - pulse select picks static or waveform
// - pin enable low tri-states pin
// - low picks prescaler, high holds count
// - timer starts on run rising edge
// - square wave frequency fx over divisor(n+1)
// - irq flag set every second timer interval, on square wave fall
// - pwm mode drives 14-bit pwm
// - pwm irq every 2^15 clocks
// - stopping timer may set irq flag
// - latch is high plus low bits 7:2
// - 2^10 basic within 2^15 secondary period
`timescale 1ns/1ps
`include "tpg_consts.vh"

module timer_pulse_generator #(
    parameter ADDR_WIDTH = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg pulse_out_pin_o,
    output reg pulse_out_pin_oe,
    output reg pulse_gen_irq_flag
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] pulse_gen_mode_reg;
    reg [7:0] modulo_low_reg;
    reg [7:0] modulo_high_reg;
    reg [7:0] latch_high_reg;
    reg [5:0] latch_low_reg;
    reg run_d_reg;
    reg [6:0] pre_cnt_reg;
    reg [7:0] int_cnt_reg;
    reg toggle_reg;

    wire mode_select_bit;
    wire run_enable_bit;
    wire reload_enable_bit;
    wire static_level_bit;
    wire pulse_select_bit;
    wire pin_drive_enable_bit;

    assign mode_select_bit = pulse_gen_mode_reg[`TPG_MODE_SEL];
    assign run_enable_bit = pulse_gen_mode_reg[`TPG_RUN_EN];
    assign reload_enable_bit = pulse_gen_mode_reg[`TPG_RELOAD_EN];
    assign static_level_bit = pulse_gen_mode_reg[`TPG_STATIC_LVL];
    assign pulse_select_bit = pulse_gen_mode_reg[`TPG_PULSE_SEL];
    assign pin_drive_enable_bit = pulse_gen_mode_reg[`TPG_PIN_EN];

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    reg aw_held_reg;
    reg w_held_reg;
    reg [ADDR_WIDTH-1:0] waddr_reg;
    reg [7:0] wbyte_reg;
    reg wlane_reg;
    wire wr_fire;
    wire wr_mode;
    wire wr_low;
    wire wr_high;
    wire wr_stat;
    wire wr_reload;
    wire wr_hit;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_mode = (waddr_reg == `TPG_MODE_OFS);
    assign wr_low = (waddr_reg == `TPG_MODULO_LOW_REG_OFS);
    assign wr_high = (waddr_reg == `TPG_MODULO_HIGH_REG_OFS);
    assign wr_stat = (waddr_reg == `TPG_STAT_OFS);
    assign wr_reload = (waddr_reg == `TPG_RELOAD_OFS);
    assign wr_hit = wr_mode || wr_low || wr_high || wr_stat || wr_reload;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= {ADDR_WIDTH{1'b0}};
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TPG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                waddr_reg <= {s_axi_awaddr[ADDR_WIDTH-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    wire wr_byte;
    assign wr_byte = wr_fire && wlane_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_gen_mode_reg <= `TPG_MODE_RST;
            modulo_low_reg <= `TPG_MOD_RST;
            modulo_high_reg <= `TPG_MOD_RST;
        end else if (wr_byte) begin
            if (wr_mode) begin
                // reserved bits 6 and 2 never hold a one
                pulse_gen_mode_reg <= wbyte_reg & `TPG_MODE_RMASK;
            end
            if (wr_reload) begin
                pulse_gen_mode_reg[`TPG_RELOAD_EN] <= wbyte_reg[0];
            end
            if (wr_low) begin
                modulo_low_reg <= wbyte_reg;
            end
            if (wr_high) begin
                modulo_high_reg <= wbyte_reg;
            end
        end
    end

    // ----------------------------------------
    // modulo latch
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            latch_high_reg <= `TPG_MOD_RST;
            latch_low_reg <= 6'h00;
        end else if (reload_enable_bit) begin
            // high plus low 7:2
            // transfer is continuous while enabled, so both halves
            // arrive together once software sets the bit again
            latch_high_reg <= modulo_high_reg;
            latch_low_reg <= modulo_low_reg[7:2];
        end
    end

    // ----------------------------------------
    // timer mode
    // ----------------------------------------
    wire timer_run;
    wire pwm_run;
    reg [6:0] half_div;
    wire pre_tick;
    wire terminal;
    wire toggle_fall;

    assign timer_run = run_enable_bit && mode_select_bit;
    assign pwm_run = run_enable_bit && !mode_select_bit;

    // one-hot divisor decode
    // the counter steps at half the divisor so that a full square
    // wave cycle, two toggles, spans divisor times (n+1) clocks
    always @* begin
        case (latch_low_reg[4:0])
            5'h01: half_div = 7'h7F;
            5'h02: half_div = 7'h3F;
            5'h04: half_div = 7'h1F;
            5'h08: half_div = 7'h0F;
            5'h10: half_div = 7'h07;
            default: half_div = 7'h7F;
        endcase
    end

    assign pre_tick = timer_run && (pre_cnt_reg == half_div);
    assign terminal = pre_tick && (int_cnt_reg == latch_high_reg);

    always @(posedge aclk) begin
        if (!aresetn) begin
            run_d_reg <= 1'b0;
            pre_cnt_reg <= 7'h00;
            int_cnt_reg <= 8'h00;
            toggle_reg <= 1'b0;
        end else begin
            run_d_reg <= timer_run;
            if (!timer_run || !run_d_reg) begin
                pre_cnt_reg <= 7'h00;
                int_cnt_reg <= 8'h00;
            end else if (pre_tick) begin
                pre_cnt_reg <= 7'h00;
                if (terminal) begin
                    int_cnt_reg <= 8'h00;
                end else begin
                    int_cnt_reg <= int_cnt_reg + 8'h01;
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 7'h01;
            end
            if (!timer_run) begin
                toggle_reg <= 1'b0;
            end else if (terminal) begin
                toggle_reg <= !toggle_reg;
            end
        end
    end

    assign toggle_fall = toggle_reg && (!timer_run || terminal);

    // ----------------------------------------
    // pwm mode
    // ----------------------------------------
    wire pwm_wave;
    wire pwm_period_end;

    pwm_core #(
        .BASIC_BITS(`TPG_BASIC_BITS),
        .SECOND_BITS(`TPG_SECOND_BITS),
        .PWM_BITS(`TPG_PWM_BITS)
    ) u_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(pwm_run),
        .latch_value({latch_high_reg, latch_low_reg}),
        .pwm_out_reg(pwm_wave),
        .period_end_reg(pwm_period_end)
    );

    // ----------------------------------------
    // interrupt request flag
    // ----------------------------------------
    wire irq_set;
    wire irq_clr;

    assign irq_set = toggle_fall || (pwm_period_end && pwm_run);
    assign irq_clr = wr_byte && wr_stat && wbyte_reg[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_gen_irq_flag <= 1'b0;
        end else if (irq_set) begin
            pulse_gen_irq_flag <= 1'b1;
        end else if (irq_clr) begin
            pulse_gen_irq_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // output pin
    // ----------------------------------------
    reg pin_level_next;

    always @* begin
        if (pulse_select_bit) begin
            pin_level_next = mode_select_bit ? toggle_reg : pwm_wave;
        end else begin
            pin_level_next = static_level_bit;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_out_pin_o <= 1'b0;
            pulse_out_pin_oe <= 1'b0;
        end else begin
            pulse_out_pin_o <= pin_level_next;
            pulse_out_pin_oe <= pin_drive_enable_bit;
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    reg [7:0] rd_byte;
    reg rd_hit;
    wire [ADDR_WIDTH-1:0] raddr;

    assign s_axi_arready = !s_axi_rvalid;
    assign raddr = {s_axi_araddr[ADDR_WIDTH-1:2], 2'b00};

    always @* begin
        rd_hit = 1'b1;
        case (raddr)
            `TPG_MODE_OFS: rd_byte = pulse_gen_mode_reg;
            // low two bits carry nothing useful, read as zero
            `TPG_MODULO_LOW_REG_OFS: rd_byte = {modulo_low_reg[7:2], 2'b00};
            `TPG_MODULO_HIGH_REG_OFS: rd_byte = modulo_high_reg;
            `TPG_STAT_OFS: rd_byte = {6'h00, toggle_reg, pulse_gen_irq_flag};
            `TPG_RELOAD_OFS: rd_byte = {7'h00, reload_enable_bit};
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TPG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// [pin_load.sv]
/*
 * load on the output pin: a pull-up and a filter that sums low clocks.
 * assumes the same clock as the block under test.
 */
`timescale 1ns/1ps
module pin_load (
    input wire aclk,
    input wire pin_o,
    input wire pin_oe,
    output reg [31:0] low_total = 32'h0
);
    // ----------------------------------------
    // filter
    // ----------------------------------------
    // released pin goes to the pull-up level, never holds the last value
    wire pin = pin_oe ? pin_o : 1'h1;
    always @(posedge aclk) begin
        if (!pin)
            low_total <= low_total + 32'h1;
    end
endmodule

// [timer_pulse_generator_asserts.sv]
/*
 * bus, pin and flag checks for the timer / pulse generator.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module timer_pulse_generator_asserts (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire pulse_out_pin_oe,
    input wire pulse_gen_irq_flag
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_read_answer: assert property (rd_taken |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or wide");
    chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write answer repeated");
    chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer repeated");
    chk_busy_refuse: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    chk_pin_follows: assert property ($rose(pulse_out_pin_oe) |->
        $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("pin enable without write");
    chk_irq_sticky: assert property ($past(aresetn) &&
        $fell(pulse_gen_irq_flag) |-> $rose(s_axi_bvalid))
        else $error("flag dropped without write");
    chk_reset_quiet: assert property ($rose(aresetn) |->
        !s_axi_bvalid && !s_axi_rvalid && !pulse_out_pin_oe &&
        !pulse_gen_irq_flag) else $error("not idle after reset");
endmodule
bind timer_pulse_generator timer_pulse_generator_asserts
    timer_pulse_generator_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pulse_out_pin_oe, .pulse_gen_irq_flag);

// [timer_pulse_generator_test.sv]
/*
 * register level test of the timer / pulse generator over axi4-lite.
 * assumes the pin load model and the bound checker alongside.
 */
`timescale 1ns/1ps
`include "tpg_consts.vh"
module timer_pulse_generator_test;
    reg aclk = 1'h0;
    reg aresetn = 1'h0;
    reg [11:0] awaddr = 12'h0;
    reg [11:0] araddr = 12'h0;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'h0;
    reg wvalid = 1'h0;
    reg bready = 1'h0;
    reg arvalid = 1'h0;
    reg rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, low_total;
    reg [1:0] resp;
    reg [31:0] rd_val;
    integer errors = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i, t, l;

    timer_pulse_generator timer_pulse_generator_i (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pulse_out_pin_o(pin_o),
        .pulse_out_pin_oe(pin_oe), .pulse_gen_irq_flag(irq));
    pin_load pin_load_i (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .low_total(low_total));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    task end_of_test;
        begin
            if (errors == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task timeout;
        begin
            errors = errors + 1;
            end_of_test;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: seen %h expected %h",
                    $time, seen, exp);
            end
        end
    endtask
    // handshakes sampled at the falling edge, acted on at the rising one
    task wr(input [11:0] a, input [31:0] d);
        integer n;
        reg aw_t, w_t, done;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            done = 1'h0;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(negedge aclk);
                aw_t = awvalid & awready;
                w_t = wvalid & wready;
                done = bvalid;
                resp = bresp;
                @(posedge aclk);
                if (aw_t) awvalid <= 1'h0;
                if (w_t) wvalid <= 1'h0;
            end
            bready <= 1'h0;
            if (!done) timeout;
        end
    endtask
    task rd(input [11:0] a);
        integer n;
        reg ar_t, done;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            done = 1'h0;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(negedge aclk);
                ar_t = arvalid & arready;
                done = rvalid;
                resp = rresp;
                rd_val = rdata;
                @(posedge aclk);
                if (ar_t) arvalid <= 1'h0;
            end
            rready <= 1'h0;
            if (!done) timeout;
        end
    endtask
    task wait_for(input s, input v);
        integer n;
        begin
            n = 0;
            @(negedge aclk);
            while ((s ? irq : pin_o) !== v) begin
                n = n + 1;
                if (n > 40000) timeout;
                @(negedge aclk);
            end
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge aclk);
            @(negedge aclk);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`TPG_MODE_OFS);
        check(rd_val, 32'h0);
        check(pin_oe, 1'h0);
        wr(`TPG_MODE_OFS, 32'hFF);
        rd(`TPG_MODE_OFS);
        check(rd_val, 32'hBB);
        wr(`TPG_RELOAD_OFS, 32'h0);
        rd(`TPG_MODE_OFS);
        check(rd_val, 32'hB3);
        wr(12'hF80, 32'h1);
        check(resp, 2'h2);
        rd(12'hF80);
        check(resp, 2'h2);
        check(rd_val, 32'h0);
        wr(`TPG_MODE_OFS, 32'h90);
        settle;
        check({pin_oe, pin_o}, 2'h3);
        wr(`TPG_MODE_OFS, 32'h80);
        settle;
        check({pin_oe, pin_o}, 2'h2);
        wr(`TPG_MODE_OFS, 32'h10);
        settle;
        check(pin_oe, 1'h0);
        // one interval per prescaler code, n varied as well
        for (i = 0; i < 5; i = i + 1) begin
            wr(`TPG_MODULO_LOW_REG_OFS, 32'h4 << i);
            wr(`TPG_MODULO_HIGH_REG_OFS, i + 1);
            wr(`TPG_MODE_OFS, 32'hA9);
            wr(`TPG_MODE_OFS, 32'hAB);
            wait_for(0, 0);
            wait_for(0, 1);
            t = cyc;
            wait_for(0, 0);
            check(cyc - t, (256 >> i) * (i + 2) / 2);
        end
        wr(`TPG_STAT_OFS, 32'h1);
        wait_for(1, 1);
        t = cyc;
        wr(`TPG_STAT_OFS, 32'h1);
        wait_for(1, 1);
        check(cyc - t, 96);
        wait_for(0, 1);
        wr(`TPG_STAT_OFS, 32'h1);
        wr(`TPG_MODE_OFS, 32'hA9);
        settle;
        check(irq, 1'h1);
        rd(`TPG_STAT_OFS);
        check(rd_val, 32'h1);
        wr(`TPG_STAT_OFS, 32'h1);
        l = pin_o;
        repeat (600) @(posedge aclk);
        @(negedge aclk);
        check({irq, pin_o}, {1'h0, l[0]});
        // fraction of 5 sixteenths gives ten extra low clocks
        wr(`TPG_RELOAD_OFS, 32'h0);
        wr(`TPG_MODULO_HIGH_REG_OFS, 32'h40);
        wr(`TPG_MODULO_LOW_REG_OFS, 32'h14);
        wr(`TPG_MODE_OFS, 32'hAA);
        wait_for(1, 1);
        t = cyc;
        l = low_total;
        wr(`TPG_STAT_OFS, 32'h1);
        wait_for(1, 1);
        check(cyc - t, 32768);
        check(low_total - l, 8202);
        wr(`TPG_MODE_OFS, 32'h0);
        settle;
        check(pin_oe, 1'h0);
        end_of_test;
    end
endmodule
